// file: src/rps_top.sv
// remappable pin select: routing registers, write lock, shadow check
//
// Functional notes
// RQ1 - each peripheral input has 5-bit pin selector
// RQ2 - up to 26 pins; others unselectable
// RQ3 - each pin has 5-bit output selector
// RQ4 - input and output routing are independent
// RQ5 - code zero leaves pin to port
// RQ6 - codes 1,2 route comparator outputs
// RQ7 - codes 3-6 route serial port outputs
// RQ8 - codes 7-12 route both SPI outputs
// RQ9 - codes 13-15 route codec outputs
// RQ10 - code 16 routes CAN; 17 unused
// RQ11 - codes 18-21 route compare outputs
// RQ12 - locked routing writes complete but change nothing
// RQ13 - lock bit six of osc control
// RQ14 - keys 0x46 then 0x57 precede lock change
// RQ15 - software changes lock in next write
// RQ16 - lock holds until changed, no auto relock
// RQ17 - shadow mismatch raises configuration reset
// RQ18 - fuse active: set lock stays till reset
// RQ19 - fuse active allows single write session
// RQ20 - input code 11111 grounds; reset all ones
// RQ21 - input code 11001 selects pin 25
// RQ22 - allowed writes also update shadows
// RQ23 - unassigned output code acts like zero
`timescale 1ns/100ps
`default_nettype none
module rps_top #(
    parameter int unsigned N_PIN = rps_pkg::N_PIN_DEF,
    parameter int unsigned N_IN  = rps_pkg::N_IN_DEF
) (
    input  wire logic                          clk_sys_i,
    input  wire logic                          srst_i,
    input  wire logic                          one_time_lock_fuse_i,
    input  wire logic                          osc_wr_i,
    input  wire logic [7:0]                    osc_wr_data_i,
    input  wire logic                          route_wr_i,
    input  wire logic                          route_wr_out_i,
    input  wire logic [4:0]                    route_wr_idx_i,
    input  wire logic [4:0]                    route_wr_data_i,
    input  wire logic                          route_rd_out_i,
    input  wire logic [4:0]                    route_rd_idx_i,
    input  wire logic [N_PIN-1:0]              pin_in_i,
    input  wire logic [N_PIN-1:0]              port_lat_i,
    input  wire logic [N_PIN-1:0]              port_dir_in_i,
    input  wire logic [rps_pkg::N_OUT_SRC-1:0] periph_out_i,
    output logic                               map_write_lock_o,
    output logic                               route_wr_ack_o,
    output logic      [4:0]                    route_rd_data_o,
    output logic                               cfg_mismatch_rst_o,
    output logic      [N_IN-1:0]               periph_in_o,
    output logic      [N_PIN-1:0]              pin_out_o,
    output logic      [N_PIN-1:0]              pin_oe_o
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic idx_ok(input logic [4:0] idx, input int unsigned lim);
        return 32'(idx) < lim;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    rps_pkg::rps_key_state_type key_ff;
    rps_pkg::rps_key_state_type nxt_key;
    logic       map_write_lock_ff;
    logic       set_once_ff;
    logic       mismatch_ff;
    logic       ack_ff;
    logic [4:0] rd_ff;
    logic [4:0] in_route_ff   [N_IN];
    logic [4:0] in_shadow_ff  [N_IN];
    logic [4:0] out_route_ff  [N_PIN];
    logic [4:0] out_shadow_ff [N_PIN];
    logic       wr_allowed;
    logic       lock_change;
    logic       differ;

    // ------------------------------------------------------------
    // unlock key sequence
    // ------------------------------------------------------------
    // any other osc write between the keys aborts the sequence, except a repeated first key, which keeps it armed
    always_comb
    begin
        nxt_key = rps_pkg::RPS_KEY_IDLE;
        if (!osc_wr_i)
            nxt_key = key_ff;
        else
        begin
            case (key_ff)
                rps_pkg::RPS_KEY_IDLE:
                    if (osc_wr_data_i == rps_pkg::OSC_KEY_A)
                        nxt_key = rps_pkg::RPS_KEY_ONE; // [RQ14]
                rps_pkg::RPS_KEY_ONE:
                    if (osc_wr_data_i == rps_pkg::OSC_KEY_B)
                        nxt_key = rps_pkg::RPS_KEY_TWO; // [RQ14]
                    else if (osc_wr_data_i == rps_pkg::OSC_KEY_A)
                        nxt_key = rps_pkg::RPS_KEY_ONE;
                rps_pkg::RPS_KEY_TWO:
                    nxt_key = rps_pkg::RPS_KEY_IDLE; // [RQ15]
                default:
                    nxt_key = rps_pkg::RPS_KEY_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
            key_ff <= rps_pkg::RPS_KEY_IDLE;
        else
            key_ff <= nxt_key;
    end

    // ------------------------------------------------------------
    // map write lock
    // ------------------------------------------------------------
    // with the fuse active a lock once set cannot be opened again
    assign lock_change = osc_wr_i && (key_ff == rps_pkg::RPS_KEY_TWO)
                         && !(one_time_lock_fuse_i && set_once_ff); // [RQ18] [RQ19]

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
            map_write_lock_ff <= rps_pkg::LOCK_RST;
        else if (lock_change)
            map_write_lock_ff <= osc_wr_data_i[rps_pkg::LOCK_BIT_POS]; // [RQ13] [RQ14]
    end // [RQ16]

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
            set_once_ff <= 1'b0;
        else if (lock_change && osc_wr_data_i[rps_pkg::LOCK_BIT_POS])
            set_once_ff <= 1'b1; // [RQ18]
    end

    // ------------------------------------------------------------
    // routing registers and shadows
    // ------------------------------------------------------------
    assign wr_allowed = route_wr_i && !map_write_lock_ff; // [RQ12]

    always_ff @(posedge clk_sys_i)
    begin
        for (int i = 0; i < N_IN; i++)
        begin
            if (srst_i)
            begin
                in_route_ff[i]  <= rps_pkg::IN_SEL_RST; // [RQ20]
                in_shadow_ff[i] <= rps_pkg::IN_SEL_RST;
            end
            else if (wr_allowed && !route_wr_out_i && (32'(route_wr_idx_i) == i))
            begin
                in_route_ff[i]  <= route_wr_data_i; // [RQ1] [RQ4]
                in_shadow_ff[i] <= route_wr_data_i; // [RQ22]
            end
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        for (int p = 0; p < N_PIN; p++)
        begin
            if (srst_i)
            begin
                out_route_ff[p]  <= rps_pkg::OUT_SEL_RST;
                out_shadow_ff[p] <= rps_pkg::OUT_SEL_RST;
            end
            else if (wr_allowed && route_wr_out_i && (32'(route_wr_idx_i) == p))
            begin
                out_route_ff[p]  <= route_wr_data_i; // [RQ3] [RQ4]
                out_shadow_ff[p] <= route_wr_data_i; // [RQ22]
            end
        end
    end

    // every write is acknowledged, locked or not, so software sees no error
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
            ack_ff <= 1'b0;
        else
            ack_ff <= route_wr_i; // [RQ12]
    end

    // ------------------------------------------------------------
    // readback
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
            rd_ff <= 5'h00;
        else if (route_rd_out_i && idx_ok(route_rd_idx_i, N_PIN))
            rd_ff <= out_route_ff[route_rd_idx_i];
        else if (!route_rd_out_i && idx_ok(route_rd_idx_i, N_IN))
            rd_ff <= in_route_ff[route_rd_idx_i];
        else
            rd_ff <= 5'h00;
    end

    // ------------------------------------------------------------
    // continuous shadow monitor
    // ------------------------------------------------------------
    always_comb
    begin
        differ = 1'b0;
        for (int i = 0; i < N_IN; i++)
            if (in_route_ff[i] != in_shadow_ff[i])
                differ = 1'b1;
        for (int p = 0; p < N_PIN; p++)
            if (out_route_ff[p] != out_shadow_ff[p])
                differ = 1'b1;
    end

    // held until system reset; only an upset can make copies differ
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
            mismatch_ff <= 1'b0;
        else if (differ)
            mismatch_ff <= 1'b1; // [RQ17]
    end

    // ------------------------------------------------------------
    // routing matrices
    // ------------------------------------------------------------
    rps_in_matrix #(
        .N_PIN (N_PIN),
        .N_IN  (N_IN)
    ) u_in_matrix (
        .clk_sys_i   (clk_sys_i),
        .srst_i      (srst_i),
        .sel_i       (in_route_ff),
        .pin_in_i    (pin_in_i),
        .periph_in_o (periph_in_o)
    );

    rps_out_matrix #(
        .N_PIN (N_PIN)
    ) u_out_matrix (
        .clk_sys_i     (clk_sys_i),
        .srst_i        (srst_i),
        .sel_i         (out_route_ff),
        .periph_out_i  (periph_out_i),
        .port_lat_i    (port_lat_i),
        .port_dir_in_i (port_dir_in_i),
        .pin_out_o     (pin_out_o),
        .pin_oe_o      (pin_oe_o)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign map_write_lock_o   = map_write_lock_ff;
    assign route_wr_ack_o     = ack_ff;
    assign route_rd_data_o    = rd_ff;
    assign cfg_mismatch_rst_o = mismatch_ff;

endmodule // rps_top
`default_nettype wire

// file: src/rps_pkg.sv
// constants and helpers shared by the remappable pin select block
`default_nettype none
package rps_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int unsigned SEL_W     = 5;
    localparam int unsigned N_PIN_DEF = 26;
    localparam int unsigned N_IN_DEF  = 25;
    localparam int unsigned N_OUT_SRC = 20;

    // ------------------------------------------------------------
    // selector codes and reset values
    // ------------------------------------------------------------
    localparam logic [4:0] IN_SEL_GND   = 5'h1f;
    localparam logic [4:0] IN_SEL_RST   = 5'h1f;
    localparam logic [4:0] OUT_SEL_RST  = 5'h00;
    localparam logic [4:0] OUT_NULL     = 5'h00;
    localparam logic [4:0] OUT_CMP_A    = 5'h01;
    localparam logic [4:0] OUT_CMP_B    = 5'h02;
    localparam logic [4:0] OUT_SER_ATX  = 5'h03;
    localparam logic [4:0] OUT_SER_BRTS = 5'h06;
    localparam logic [4:0] OUT_SPI_ADO  = 5'h07;
    localparam logic [4:0] OUT_SPI_BSS  = 5'h0c;
    localparam logic [4:0] OUT_CODEC_D  = 5'h0d;
    localparam logic [4:0] OUT_CODEC_FS = 5'h0f;
    localparam logic [4:0] OUT_CAN_TX   = 5'h10;
    localparam logic [4:0] OUT_SPARE    = 5'h11;
    localparam logic [4:0] OUT_CMP_ONE  = 5'h12;
    localparam logic [4:0] OUT_CMP_FOUR = 5'h15;

    // ------------------------------------------------------------
    // lock control
    // ------------------------------------------------------------
    localparam logic [7:0]  OSC_KEY_A    = 8'h46;
    localparam logic [7:0]  OSC_KEY_B    = 8'h57;
    localparam int unsigned LOCK_BIT_POS = 6;
    localparam logic        LOCK_RST     = 1'b0;

    typedef enum logic [1:0] {
        RPS_KEY_IDLE = 2'b00,
        RPS_KEY_ONE  = 2'b01,
        RPS_KEY_TWO  = 2'b11
    } rps_key_state_type;

    // output code to peripheral output index; valid flag in msb
    function automatic logic [5:0] out_src_index(input logic [4:0] code);
        logic [5:0] res;
        res = 6'h00;
        if ((code >= OUT_CMP_A) && (code <= OUT_CAN_TX))
            res = {1'b1, code - 5'h01};
        else if ((code >= OUT_CMP_ONE) && (code <= OUT_CMP_FOUR))
            res = {1'b1, code - 5'h02};
        return res;
    endfunction

endpackage
`default_nettype wire

// file: src/rps_in_matrix.sv
// peripheral input routing: one pin per peripheral input
`timescale 1ns/100ps
`default_nettype none
module rps_in_matrix #(
    parameter int unsigned N_PIN = rps_pkg::N_PIN_DEF,
    parameter int unsigned N_IN  = rps_pkg::N_IN_DEF
) (
    input  wire logic             clk_sys_i,
    input  wire logic             srst_i,
    input  wire logic [4:0]       sel_i [N_IN],
    input  wire logic [N_PIN-1:0] pin_in_i,
    output logic      [N_IN-1:0]  periph_in_o
);

    // ------------------------------------------------------------
    // selection
    // ------------------------------------------------------------
    // codes beyond the present pins fall back to ground like 11111
    always_ff @(posedge clk_sys_i)
    begin
        for (int i = 0; i < N_IN; i++)
        begin
            if (srst_i)
                periph_in_o[i] <= 1'b0;
            else if (32'(sel_i[i]) < N_PIN)
                periph_in_o[i] <= pin_in_i[sel_i[i]]; // [RQ1] [RQ21]
            else
                periph_in_o[i] <= 1'b0; // [RQ20] [RQ2]
        end
    end

endmodule // rps_in_matrix
`default_nettype wire

// file: src/rps_out_matrix.sv
// pin output routing: one peripheral output per pin
`timescale 1ns/100ps
`default_nettype none
module rps_out_matrix #(
    parameter int unsigned N_PIN = rps_pkg::N_PIN_DEF
) (
    input  wire logic                       clk_sys_i,
    input  wire logic                       srst_i,
    input  wire logic [4:0]                 sel_i [N_PIN],
    input  wire logic [rps_pkg::N_OUT_SRC-1:0] periph_out_i,
    input  wire logic [N_PIN-1:0]           port_lat_i,
    input  wire logic [N_PIN-1:0]           port_dir_in_i,
    output logic      [N_PIN-1:0]           pin_out_o,
    output logic      [N_PIN-1:0]           pin_oe_o
);

    // ------------------------------------------------------------
    // selection
    // ------------------------------------------------------------
    logic [5:0] src [N_PIN];

    always_comb
    begin
        for (int p = 0; p < N_PIN; p++)
            src[p] = rps_pkg::out_src_index(sel_i[p]); // [RQ6] [RQ7] [RQ8] [RQ9] [RQ10] [RQ11]
    end

    // a selected peripheral always owns the driver
    always_ff @(posedge clk_sys_i)
    begin
        for (int p = 0; p < N_PIN; p++)
        begin
            if (srst_i)
            begin
                pin_out_o[p] <= 1'b0;
                pin_oe_o[p]  <= 1'b0;
            end
            else if (src[p][5])
            begin
                pin_out_o[p] <= periph_out_i[src[p][4:0]]; // [RQ3]
                pin_oe_o[p]  <= 1'b1;
            end
            else
            begin
                pin_out_o[p] <= port_lat_i[p]; // [RQ5] [RQ23]
                pin_oe_o[p]  <= ~port_dir_in_i[p];
            end
        end
    end

endmodule // rps_out_matrix
`default_nettype wire

// file: test/rps_properties.sv
// concurrent checks on the pin select block ports
`timescale 1ns/100ps
`default_nettype none
module rps_properties #(
    parameter int unsigned N_PIN = 26,
    parameter int unsigned N_IN  = 25
) (
    input wire logic       clk_sys_i,
    input wire logic       srst_i,
    input wire logic       one_time_lock_fuse_i,
    input wire logic       osc_wr_i,
    input wire logic [7:0] osc_wr_data_i,
    input wire logic       route_wr_i,
    input wire logic       route_wr_out_i,
    input wire logic [4:0] route_wr_idx_i,
    input wire logic [4:0] route_wr_data_i,
    input wire logic       route_rd_out_i,
    input wire logic [4:0] route_rd_idx_i,
    input wire logic       map_write_lock_o,
    input wire logic       route_wr_ack_o,
    input wire logic [4:0] route_rd_data_o,
    input wire logic       cfg_mismatch_rst_o
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    logic in_rng;
    logic same_idx;
    assign in_rng   = route_wr_out_i ? (route_wr_idx_i < N_PIN) : (route_wr_idx_i < N_IN);
    assign same_idx = route_wr_i && (route_wr_out_i == route_rd_out_i)
                      && (route_wr_idx_i == route_rd_idx_i);
    // readback held one more cycle so the new value can be seen
    sequence s_open_wr;
        (!map_write_lock_o && in_rng && same_idx) ##1 $stable(route_rd_idx_i);
    endsequence
    sequence s_shut_wr;
        (map_write_lock_o && same_idx) ##1 $stable(route_rd_idx_i);
    endsequence
    sequence s_keys;
        (osc_wr_i && (osc_wr_data_i == 8'h46)) ##1 (osc_wr_i && (osc_wr_data_i == 8'h57))
            ##1 (osc_wr_i && !one_time_lock_fuse_i);
    endsequence
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    // ack is the strobe delayed by one edge, so it shows at the end of the antecedent
    AST_ACK_PULSE: assert property (
        route_wr_i ##1 !route_wr_i |-> route_wr_ack_o ##1 !route_wr_ack_o)
        else $error("write ack not a single pulse");
    AST_WR_TAKES: assert property (
        s_open_wr |=> route_rd_data_o == $past(route_wr_data_i, 2))
        else $error("open write not stored");
    AST_WR_BLOCKED: assert property (
        s_shut_wr |=> route_rd_data_o == $past(route_rd_data_o))
        else $error("locked write changed selector");
    AST_KEY_LOAD: assert property (
        s_keys |=> map_write_lock_o == $past(osc_wr_data_i[6]))
        else $error("key sequence did not load lock");
    AST_LOCK_CAUSE: assert property ($changed(map_write_lock_o) |-> $past(osc_wr_i))
        else $error("lock moved without an osc write");
    AST_LOCK_STABLE: assert property (!osc_wr_i |=> $stable(map_write_lock_o))
        else $error("lock relocked on its own");
    AST_ONE_WAY: assert property (
        one_time_lock_fuse_i && map_write_lock_o |=> map_write_lock_o)
        else $error("lock cleared under fuse");
    AST_RD_RANGE: assert property (
        route_rd_out_i && (route_rd_idx_i >= N_PIN) |=> route_rd_data_o == 5'h00)
        else $error("out of range pin read not zero");
    AST_NO_MISMATCH: assert property (!cfg_mismatch_rst_o)
        else $error("mismatch reset on legal traffic");
endmodule // rps_properties
bind rps_top rps_properties #(.N_PIN(N_PIN), .N_IN(N_IN)) i_rps_properties (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .one_time_lock_fuse_i(one_time_lock_fuse_i),
    .osc_wr_i(osc_wr_i), .osc_wr_data_i(osc_wr_data_i), .route_wr_i(route_wr_i),
    .route_wr_out_i(route_wr_out_i), .route_wr_idx_i(route_wr_idx_i),
    .route_wr_data_i(route_wr_data_i), .route_rd_out_i(route_rd_out_i),
    .route_rd_idx_i(route_rd_idx_i), .map_write_lock_o(map_write_lock_o),
    .route_wr_ack_o(route_wr_ack_o), .route_rd_data_o(route_rd_data_o),
    .cfg_mismatch_rst_o(cfg_mismatch_rst_o));
`default_nettype wire

// file: test/rps_far_model.sv
// stand-in for peripherals and pads at the far side
`timescale 1ns/100ps
`default_nettype none
module rps_far_model (
    input  wire logic [4:0]  hot_i,
    input  wire logic        inv_i,
    output logic      [19:0] periph_out_o,
    output logic      [25:0] pin_in_o,
    output logic      [25:0] port_lat_o,
    output logic      [25:0] port_dir_in_o
);
    // one odd source, so a wrong pick shows as a wrong level
    assign periph_out_o  = {20{inv_i}} ^ (20'h00001 << hot_i);
    assign pin_in_o      = {26{inv_i}} ^ (26'h0000001 << hot_i);
    // port side flips too, so a stuck port mux is seen
    assign port_lat_o    = {13{2'h2}} ^ {26{inv_i}};
    assign port_dir_in_o = {13{2'h1}} ^ {26{inv_i}};
endmodule // rps_far_model
`default_nettype wire

// file: test/rps_top_tb.sv
// self-checking bench for the pin select block
`timescale 1ns/100ps
`default_nettype none
module rps_top_tb;
    logic        clk_sys_i = 1'b0;
    logic        srst_i    = 1'b1;
    logic        fuse = 1'b0, osc_wr = 1'b0, wr = 1'b0, wr_out = 1'b0, rd_out = 1'b0;
    logic [7:0]  osc_d  = 8'h00;
    logic [4:0]  wr_idx = 5'h00, wr_d = 5'h00, rd_idx = 5'h00, hot = 5'h00, rd_d;
    logic        inv = 1'b0, lock, ack, mism;
    logic [24:0] p_in;
    logic [25:0] p_out, p_oe, pi, lat, dir;
    logic [19:0] po;
    int          fails       = 0;
    int          checks_done = 0;

    initial
    begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    rps_top i_rps_top (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .one_time_lock_fuse_i(fuse),
        .osc_wr_i(osc_wr), .osc_wr_data_i(osc_d), .route_wr_i(wr), .route_wr_out_i(wr_out),
        .route_wr_idx_i(wr_idx), .route_wr_data_i(wr_d), .route_rd_out_i(rd_out),
        .route_rd_idx_i(rd_idx), .pin_in_i(pi), .port_lat_i(lat), .port_dir_in_i(dir),
        .periph_out_i(po), .map_write_lock_o(lock), .route_wr_ack_o(ack),
        .route_rd_data_o(rd_d), .cfg_mismatch_rst_o(mism), .periph_in_o(p_in),
        .pin_out_o(p_out), .pin_oe_o(p_oe));
    rps_far_model i_rps_far_model (.hot_i(hot), .inv_i(inv), .periph_out_o(po),
        .pin_in_o(pi), .port_lat_o(lat), .port_dir_in_o(dir));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [25:0] got, input logic [25:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if ((fails == 0) && (checks_done > 0))
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic do_reset();
        srst_i = 1'b1;
        repeat (12) @(negedge clk_sys_i);
        srst_i = 1'b0;
        @(negedge clk_sys_i);
    endtask
    task automatic settle();
        repeat (2) @(negedge clk_sys_i);
    endtask
    // keys then lock value, strobe held, nothing in between
    task automatic osc_seq(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
        osc_wr = 1'b1;
        osc_d  = a;
        @(negedge clk_sys_i);
        osc_d = b;
        @(negedge clk_sys_i);
        osc_d = c;
        @(negedge clk_sys_i);
        osc_wr = 1'b0;
        @(negedge clk_sys_i);
    endtask
    task automatic route_wr(input logic o, input logic [4:0] i, input logic [4:0] d);
        wr     = 1'b1;
        wr_out = o;
        wr_idx = i;
        wr_d   = d;
        @(negedge clk_sys_i);
        chk(26'(ack), 26'h1);
        wr = 1'b0;
        @(negedge clk_sys_i);
    endtask
    task automatic rd_chk(input logic o, input logic [4:0] i, input logic [4:0] e);
        rd_out = o;
        rd_idx = i;
        @(negedge clk_sys_i);
        chk(26'(rd_d), 26'(e));
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic s_reset();
        rd_chk(1'b0, 5'h00, 5'h1f);
        rd_chk(1'b0, 5'h18, 5'h1f);
        rd_chk(1'b1, 5'h19, 5'h00);
        rd_chk(1'b1, 5'h1a, 5'h00);
        chk(26'(p_in), 26'h0);
        chk(p_oe, ~dir);
        chk(26'(lock), 26'h0);
    endtask
    task automatic s_out_codes();
        logic [4:0] nulls [4] = '{5'h00, 5'h11, 5'h16, 5'h1f};
        rd_out = 1'b1;
        rd_idx = 5'h19;
        for (int k = 1; k < 22; k++)
        begin
            if (k == 17)
                continue;
            route_wr(1'b1, 5'h19, 5'(k));
            hot = (k < 17) ? 5'(k - 1) : 5'(k - 2);
            inv = 1'b0;
            settle();
            chk(26'({p_oe[25], p_out[25]}), 26'h3);
            inv = 1'b1;
            settle();
            chk(26'({p_oe[25], p_out[25]}), 26'h2);
        end
        foreach (nulls[j])
        begin
            route_wr(1'b1, 5'h19, nulls[j]);
            inv = nulls[j][0];
            settle();
            chk(26'({p_oe[25], p_out[25]}), 26'({~dir[25], lat[25]}));
        end
    endtask
    task automatic s_in_route();
        logic [4:0] sel [4] = '{5'h00, 5'h19, 5'h1a, 5'h1f};
        rd_out = 1'b0;
        rd_idx = 5'h18;
        foreach (sel[j])
        begin
            route_wr(1'b0, 5'h18, sel[j]);
            hot = sel[j];
            inv = 1'b0;
            settle();
            chk(26'(p_in[24]), 26'(j < 2));
            hot = (j < 2) ? sel[j] : 5'h00;
            inv = 1'b1;
            settle();
            chk(26'(p_in[24]), 26'h0);
        end
        rd_chk(1'b1, 5'h19, 5'h1f);
    endtask
    task automatic s_lock();
        fuse = 1'b0;
        osc_seq(8'h46, 8'h57, 8'h40);
        chk(26'(lock), 26'h1);
        rd_out = 1'b1;
        rd_idx = 5'h00;
        route_wr(1'b1, 5'h00, 5'h03);
        rd_chk(1'b1, 5'h00, 5'h00);
        osc_seq(8'h46, 8'h00, 8'h00);
        chk(26'(lock), 26'h1);
        osc_seq(8'h46, 8'h57, 8'hbf);
        chk(26'(lock), 26'h0);
        route_wr(1'b1, 5'h00, 5'h03);
        route_wr(1'b0, 5'h00, 5'h05);
        rd_chk(1'b1, 5'h00, 5'h03);
        rd_chk(1'b0, 5'h00, 5'h05);
        chk(26'(mism), 26'h0);
    endtask
    task automatic s_fuse();
        fuse = 1'b1;
        do_reset();
        route_wr(1'b0, 5'h02, 5'h07);
        rd_chk(1'b0, 5'h02, 5'h07);
        osc_seq(8'h46, 8'h57, 8'h40);
        chk(26'(lock), 26'h1);
        osc_seq(8'h46, 8'h57, 8'h00);
        chk(26'(lock), 26'h1);
        route_wr(1'b0, 5'h02, 5'h09);
        rd_chk(1'b0, 5'h02, 5'h07);
        do_reset();
        chk(26'(lock), 26'h0);
        rd_chk(1'b0, 5'h02, 5'h1f);
    endtask

    // ------------------------------------------------------------
    // run
    // ------------------------------------------------------------
    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        fails++;
        results();
    end
    initial
    begin
        do_reset();
        s_reset();
        s_out_codes();
        s_in_route();
        s_lock();
        s_fuse();
        results();
    end
endmodule // rps_top_tb
`default_nettype wire
